// file: shared/cfpa_pkg.sv
// constants for the cell fault priority arbiter
// assumes one 100 MHz clock; counter delays are counted in oscillator ticks, the short-circuit delay in clock cycles
`default_nettype none
package cfpa_pkg;
    // ==========================================
    // clock and oscillator tick
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_DIV_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================
    // counter delays, in ticks
    localparam int DLY_NORMAL_TICKS = 1000;
    localparam int DLY_SHORT_TICKS = 4;
    // ==========================================
    // short-circuit delay, fixed, not from the counter
    localparam int SC_DELAY_NS = 300;
    localparam int SC_DELAY_CYC = (SC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================
    // delay channels
    localparam int CH_OC = 0;
    localparam int CH_OD = 1;
    localparam int CH_OCUR = 2;
    localparam int CH_XCHG = 3;
    localparam int CH_NUM = 4;
    // ==========================================
    // input bit positions of the comparator bundle
    localparam int IN_OC = 0;
    localparam int IN_OD = 1;
    localparam int IN_OCUR = 2;
    localparam int IN_SC = 3;
    localparam int IN_XCHG = 4;
    localparam int IN_TST = 5;
    localparam int IN_NUM = 6;
    // ==========================================
    // reset values of the outputs
    localparam logic CHG_GATE_RST = 1'b1;
    localparam logic DSG_GATE_RST = 1'b1;
    localparam logic PULL_RST = 1'b0;
    localparam logic STANDBY_RST = 1'b0;
endpackage
`default_nettype wire

// file: shared/cfpa_tmr_if.sv
// bundle between the arbiter and its delay timers
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface cfpa_tmr_if #(parameter int N = 4);
    logic [N-1:0] run;
    logic [N-1:0] done;
    logic shorten;
    modport arb (output run, output shorten, input done);
    modport timer (input run, input shorten, output done);
endinterface
`default_nettype wire

// file: hw/cfpa_delay_timer.sv
// oscillator tick divider and one delay counter per channel
// assumes run drops within a cycle after done
`timescale 1ns/1ps
`default_nettype none
module cfpa_delay_timer
    import cfpa_pkg::*;
#(
    parameter int N = CH_NUM,
    parameter int TICK_DIV = TICK_DIV_CYC,
    parameter int NORMAL_TICKS = DLY_NORMAL_TICKS,
    parameter int SHORT_TICKS = DLY_SHORT_TICKS
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // channel bundle
    cfpa_tmr_if.timer t
);
    localparam int CW = $clog2(NORMAL_TICKS + 1);
    localparam int DW = $clog2(TICK_DIV + 1);

    initial begin
        if (SHORT_TICKS < 1 || SHORT_TICKS > NORMAL_TICKS || TICK_DIV < 1 || N < 1) begin
            $error("cfpa_delay_timer: bad parameters");
        end
    end

    // ==========================================
    // oscillator tick
    logic [DW-1:0] div_cnt;
    logic tick;
    wire div_wrap = (div_cnt == DW'(TICK_DIV - 1));

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else begin
            div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
            tick <= div_wrap;
        end
    end

    // ==========================================
    // per-channel counters
    wire [CW-1:0] term = t.shorten ? CW'(SHORT_TICKS - 1) : CW'(NORMAL_TICKS - 1);

    for (genvar ch = 0; ch < N; ch++) begin : g_ch
        logic [CW-1:0] cnt;
        assign t.done[ch] = t.run[ch] & tick & (cnt == term);
        always_ff @(posedge mclk_in) begin
            if (srst_in || !t.run[ch]) begin
                cnt <= '0;
            end else if (tick && cnt != term) begin
                cnt <= cnt + 1'b1;
            end
        end
        a_done_at_term: assert property (@(posedge mclk_in) disable iff (srst_in)
            t.done[ch] |-> (cnt == (t.shorten ? CW'(SHORT_TICKS - 1) : CW'(NORMAL_TICKS - 1))))
            else $error("delay ended at wrong count");
    end
endmodule
`default_nettype wire

// file: hw/cfpa_arbiter.sv
// priority logic of a two-cell protector: gate drives, bias and standby
// assumes comparator flags and the test pin are asynchronous levels
// What this block does
// - test pin high shortens every counter delay
// - test pin low gives full counter delays
// - short-circuit delay ignores the test pin
// - over-charge detection preempts over-discharge detection
// - over-discharge after over-charge: no standby, pull high
// - over-charge start interrupts over-discharge detection
// - over-charge state aborts over-current detection
// - over-current first pulls low; over-charge first floats
// - over-discharge state aborts over-current detection
// - over-discharge first: pull high and standby
// - short-circuit detection runs independently
// - no charger detection during discharge-side faults
// - charger delay starts once discharge gate high
// - charge gate low on over-charge or charger
// - discharge gate low on discharge-side faults
`timescale 1ns/1ps
`default_nettype none
module cfpa_arbiter
    import cfpa_pkg::*;
#(
    parameter int SC_CYC = SC_DELAY_CYC
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // comparator flags, asynchronous
    input wire logic over_chg_in,
    input wire logic over_dsg_in,
    input wire logic over_cur_in,
    input wire logic short_cir_in,
    input wire logic xs_charger_in,
    // test pin, asynchronous
    input wire logic test_shorten_in,
    // gate drives
    output logic chg_gate_out,
    output logic dsg_gate_out,
    // charger-minus bias and standby
    output logic vminus_pull_hi_out,
    output logic vminus_pull_lo_out,
    output logic standby_out
);
    localparam int SW = $clog2(SC_CYC + 1);

    initial begin
        if (SC_CYC < 1) begin
            $error("cfpa_arbiter: SC_CYC must be at least one");
        end
    end

    // ==========================================
    // input synchronisers
    wire [IN_NUM-1:0] raw = {test_shorten_in, xs_charger_in, short_cir_in,
                             over_cur_in, over_dsg_in, over_chg_in};
    logic [IN_NUM-1:0] sync1;
    logic [IN_NUM-1:0] s;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sync1 <= '0;
            s <= '0;
        end else begin
            sync1 <= raw;
            s <= sync1;
        end
    end

    wire oc_c = s[IN_OC];
    wire od_c = s[IN_OD];
    wire ocur_c = s[IN_OCUR];
    wire sc_c = s[IN_SC];
    wire xchg_c = s[IN_XCHG];

    // ==========================================
    // delay timers
    cfpa_tmr_if #(.N(CH_NUM)) tmr ();

    cfpa_delay_timer #(
        .N(CH_NUM),
        .TICK_DIV(TICK_DIV_CYC),
        .NORMAL_TICKS(DLY_NORMAL_TICKS),
        .SHORT_TICKS(DLY_SHORT_TICKS)
    ) u_timer (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .t(tmr.timer)
    );

    assign tmr.shorten = s[IN_TST];

    // ==========================================
    // confirmed states
    logic oc_st;
    logic od_st;
    logic ocur_st;
    logic sc_st;
    logic xchg_st;
    logic [SW-1:0] sc_cnt;

    wire fault_i = ocur_st | sc_st;
    wire oc_run = oc_c != oc_st;
    wire oc_det = oc_run & ~oc_st;
    wire od_run = (od_c != od_st) & ~oc_det;
    // release only once both current comparators are quiet, else a held short chatters
    wire ocur_rel = fault_i & ~ocur_c & ~sc_c;
    wire ocur_det = ~fault_i & ocur_c & ~oc_st & ~od_st;
    wire ocur_run = ocur_rel | ocur_det;
    wire xchg_block = od_run | od_st | ocur_run | fault_i | sc_c;
    wire xchg_run = (xchg_c != xchg_st) & ~xchg_block & dsg_gate_out;
    wire sc_done = sc_c & ~sc_st & (sc_cnt == SW'(SC_CYC - 1));

    assign tmr.run = {xchg_run, ocur_run, od_run, oc_run};

    wire oc_done = tmr.done[CH_OC];
    wire od_done = tmr.done[CH_OD];
    wire ocur_done = tmr.done[CH_OCUR];
    wire xchg_done = tmr.done[CH_XCHG];

    // short-circuit delay on the system clock, blind to the test pin
    always_ff @(posedge mclk_in) begin
        if (srst_in || !sc_c || sc_st) begin
            sc_cnt <= '0;
        end else if (sc_cnt != SW'(SC_CYC - 1)) begin
            sc_cnt <= sc_cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            oc_st <= 1'b0;
            od_st <= 1'b0;
            ocur_st <= 1'b0;
            sc_st <= 1'b0;
            xchg_st <= 1'b0;
        end else begin
            if (oc_done) begin
                oc_st <= ~oc_st;
            end
            if (od_done) begin
                od_st <= ~od_st;
            end
            if (ocur_done) begin
                ocur_st <= ~fault_i;
            end
            if (sc_done) begin
                sc_st <= 1'b1;
            end else if (ocur_done && fault_i) begin
                sc_st <= 1'b0;
            end
            if (xchg_done) begin
                xchg_st <= ~xchg_st;
            end
        end
    end

    // ==========================================
    // output decode
    wire next_chg_gate = ~(oc_st | xchg_st);
    wire next_dsg_gate = ~(od_st | fault_i);
    wire next_pull_hi = od_st;
    wire next_pull_lo = fault_i & ~od_st;
    wire next_standby = od_st & ~oc_st;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            chg_gate_out <= CHG_GATE_RST;
            dsg_gate_out <= DSG_GATE_RST;
            vminus_pull_hi_out <= PULL_RST;
            vminus_pull_lo_out <= PULL_RST;
            standby_out <= STANDBY_RST;
        end else begin
            chg_gate_out <= next_chg_gate;
            dsg_gate_out <= next_dsg_gate;
            vminus_pull_hi_out <= next_pull_hi;
            vminus_pull_lo_out <= next_pull_lo;
            standby_out <= next_standby;
        end
    end

    // ==========================================
    // assertions
    a_chg_gate_block: assert property (@(posedge mclk_in) disable iff (srst_in)
        $rose(oc_st) |=> !chg_gate_out ##1 !chg_gate_out || !oc_st)
        else $error("charge gate not low after over-charge");
    a_dsg_gate_block: assert property (@(posedge mclk_in) disable iff (srst_in)
        (od_st || ocur_st || sc_st) |=> !dsg_gate_out)
        else $error("discharge gate not low on fault");
    a_od_yields_oc: assert property (@(posedge mclk_in) disable iff (srst_in)
        (oc_c && !oc_st && !od_st) |-> !od_run)
        else $error("over-discharge detection ran during over-charge detection");
    a_no_standby_oc: assert property (@(posedge mclk_in) disable iff (srst_in)
        (oc_st && od_st) |=> (!standby_out && vminus_pull_hi_out))
        else $error("standby entered with over-charge held");
    a_standby_od: assert property (@(posedge mclk_in) disable iff (srst_in)
        (od_st && !oc_st) |=> (standby_out && vminus_pull_hi_out && !vminus_pull_lo_out))
        else $error("over-discharge did not bias high and stand by");
    a_pull_lo_ocur: assert property (@(posedge mclk_in) disable iff (srst_in)
        (ocur_st && !od_st) |=> (vminus_pull_lo_out && !vminus_pull_hi_out))
        else $error("over-current did not pull low");
    a_ocur_abort: assert property (@(posedge mclk_in) disable iff (srst_in)
        (!fault_i && (oc_st || od_st)) |-> !ocur_run)
        else $error("over-current detection ran after over-charge or over-discharge");
    a_xchg_blocked: assert property (@(posedge mclk_in) disable iff (srst_in)
        (od_st || fault_i || sc_c) |-> !xchg_run)
        else $error("charger detection during discharge-side fault");
    a_xchg_dsg_high: assert property (@(posedge mclk_in) disable iff (srst_in)
        xchg_run |-> dsg_gate_out)
        else $error("charger delay ran with discharge gate low");
    a_sc_fixed: assert property (@(posedge mclk_in) disable iff (srst_in)
        $rose(sc_st) |-> $past(sc_cnt) == SW'(SC_CYC - 1))
        else $error("short-circuit delay length wrong");

    c_oc_then_od: cover property (@(posedge mclk_in) disable iff (srst_in)
        oc_st ##[1:1000] (oc_st && od_st));
    c_ocur_then_od: cover property (@(posedge mclk_in) disable iff (srst_in)
        ocur_st ##[1:1000] (od_st && standby_out));
    c_short: cover property (@(posedge mclk_in) disable iff (srst_in) $rose(sc_st));
    c_xchg: cover property (@(posedge mclk_in) disable iff (srst_in) $rose(xchg_st));
endmodule
`default_nettype wire

// file: sim/cfpa_board_model.sv
// board around the arbiter: test-pin strap and the two gate fets
// assumes gate outputs are plain levels, high = fet conducting
`timescale 1ns/1ps
`default_nettype none
module cfpa_board_model (
    // bench request
    input wire logic shorten_req_in,
    // gate drives from the arbiter
    input wire logic chg_gate_in,
    input wire logic dsg_gate_in,
    // strap and fet state
    output logic test_pin_out,
    output logic chg_fet_on_out,
    output logic dsg_fet_on_out
);
    // strapped to the negative rail unless a shortened run is asked for
    assign test_pin_out = shorten_req_in ? 1'b1 : 1'b0;
    assign chg_fet_on_out = chg_gate_in;
    assign dsg_fet_on_out = dsg_gate_in;
endmodule
`default_nettype wire

// file: sim/tb_cfpa_arbiter.sv
// self-checking bench for the fault priority arbiter
// assumes the package timing; long waits use the shortened delays
`timescale 1ns/1ps
`default_nettype none
module tb_cfpa_arbiter;
    import cfpa_pkg::*;
    localparam int CHG = 4;
    localparam int DSG = 3;
    localparam int PHI = 2;
    localparam int PLO = 1;
    localparam int STB = 0;
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic oc = 1'b0, od = 1'b0, ocur = 1'b0, sc = 1'b0, xs = 1'b0, shorten = 1'b0;
    logic tst, chg_g, dsg_g, chg_on, dsg_on, phi, plo, stb;
    logic [4:0] obs;
    int n_mismatch = 0;
    int checks = 0;
    int t;
    assign obs = {chg_on, dsg_on, phi, plo, stb};
    initial begin
        forever #(CLK_PERIOD_NS / 2) mclk_in = ~mclk_in;
    end
    cfpa_arbiter u_cfpa_arbiter (.mclk_in(mclk_in), .srst_in(srst_in), .over_chg_in(oc),
        .over_dsg_in(od), .over_cur_in(ocur), .short_cir_in(sc), .xs_charger_in(xs),
        .test_shorten_in(tst), .chg_gate_out(chg_g), .dsg_gate_out(dsg_g),
        .vminus_pull_hi_out(phi), .vminus_pull_lo_out(plo), .standby_out(stb));
    cfpa_board_model u_cfpa_board_model (.shorten_req_in(shorten), .chg_gate_in(chg_g),
        .dsg_gate_in(dsg_g), .test_pin_out(tst), .chg_fet_on_out(chg_on),
        .dsg_fet_on_out(dsg_on));
    // ==========================================
    // tasks
    task automatic step(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic wait_bit(input string name, input int i, input logic exp, input int bound);
        int k;
        for (k = 0; k < bound && obs[i] !== exp; k++) step(1);
        cmp(name, exp, obs[i]);
        if (obs[i] !== exp) summarize();
    endtask
    task automatic hold_bit(input string name, input int i, input logic exp, input int n);
        int k;
        for (k = 0; k < n && obs[i] === exp; k++) step(1);
        cmp(name, exp, obs[i]);
    endtask
    task automatic rst(input logic s);
        {oc, od, ocur, sc, xs} = '0;
        shorten = s;
        srst_in = 1'b1;
        step(3);
        srst_in = 1'b0;
        step(1);
    endtask
    // ==========================================
    // tests
    initial begin
        step(10);
        cmp("chg_gate", CHG_GATE_RST, obs[CHG]);
        cmp("dsg_gate", DSG_GATE_RST, obs[DSG]);
        cmp("pull_hi", PULL_RST, obs[PHI]);
        cmp("pull_lo", PULL_RST, obs[PLO]);
        cmp("standby", STANDBY_RST, obs[STB]);
        $display("test reset done");
        rst(1'b0);
        oc = 1'b1;
        hold_bit("chg_gate", CHG, 1'b1, 1000);
        $display("test normal delay done");
        rst(1'b1);
        oc = 1'b1;
        wait_bit("chg_gate", CHG, 1'b0, 800);
        oc = 1'b0;
        wait_bit("chg_gate", CHG, 1'b1, 800);
        $display("test shortened delay done");
        for (t = 0; t < 2; t++) begin
            rst(t[0]);
            oc = 1'b1;
            sc = 1'b1;
            hold_bit("dsg_gate", DSG, 1'b1, 28);
            wait_bit("dsg_gate", DSG, 1'b0, 8);
            cmp("pull_lo", 1'b1, obs[PLO]);
        end
        hold_bit("dsg_gate", DSG, 1'b0, 500);
        sc = 1'b0;
        wait_bit("dsg_gate", DSG, 1'b1, 800);
        cmp("pull_lo", 1'b0, obs[PLO]);
        $display("test short circuit done");
        rst(1'b1);
        od = 1'b1;
        xs = 1'b1;
        wait_bit("dsg_gate", DSG, 1'b0, 800);
        cmp("pull_hi", 1'b1, obs[PHI]);
        cmp("standby", 1'b1, obs[STB]);
        hold_bit("chg_gate", CHG, 1'b1, 700);
        od = 1'b0;
        wait_bit("dsg_gate", DSG, 1'b1, 800);
        hold_bit("chg_gate", CHG, 1'b1, 299);
        wait_bit("chg_gate", CHG, 1'b0, 800);
        $display("test over-discharge and charger done");
        rst(1'b1);
        od = 1'b1;
        step(300);
        oc = 1'b1;
        wait_bit("chg_gate", CHG, 1'b0, 800);
        cmp("dsg_gate", 1'b1, obs[DSG]);
        wait_bit("dsg_gate", DSG, 1'b0, 800);
        cmp("standby", 1'b0, obs[STB]);
        cmp("pull_hi", 1'b1, obs[PHI]);
        $display("test charge over discharge done");
        rst(1'b1);
        ocur = 1'b1;
        wait_bit("dsg_gate", DSG, 1'b0, 800);
        cmp("pull_lo", 1'b1, obs[PLO]);
        cmp("standby", 1'b0, obs[STB]);
        od = 1'b1;
        wait_bit("standby", STB, 1'b1, 800);
        cmp("pull_lo", 1'b0, obs[PLO]);
        cmp("pull_hi", 1'b1, obs[PHI]);
        rst(1'b1);
        od = 1'b1;
        wait_bit("dsg_gate", DSG, 1'b0, 800);
        ocur = 1'b1;
        hold_bit("pull_lo", PLO, 1'b0, 800);
        rst(1'b1);
        oc = 1'b1;
        wait_bit("chg_gate", CHG, 1'b0, 800);
        ocur = 1'b1;
        hold_bit("dsg_gate", DSG, 1'b1, 800);
        cmp("pull_lo", 1'b0, obs[PLO]);
        $display("test over-current overlap done");
        summarize();
    end
endmodule
`default_nettype wire
